// file: design/logical_shifter.sv
`timescale 1ns/10ps
`include "ssu_defines.svh"

module logical_shifter (
    shift_req_if.shifter port
);
    import ssu_pkg::*;

    logic [`SSU_WORD_W-1:0] word_out;
    logic [`SSU_WORD_W-1:0] half_out;
    logic [`SSU_WCNT_W-1:0] word_mag;
    logic [`SSU_HCNT_W-1:0] half_cnt;
    logic [`SSU_HCNT_W-1:0] half_mag;

    // Magnitude of -32 is 6'h20: a shift by 32 of a 32-bit value clears it
    assign word_mag = port.count[`SSU_WCNT_W-1] ? (~port.count + 6'h01) : port.count;
    always_comb begin
        if (port.count[`SSU_WCNT_W-1]) begin
            word_out = port.value >> word_mag;
        end else begin
            word_out = port.value << word_mag;
        end
    end

    assign half_cnt = port.count[`SSU_HCNT_W-1:0];
    assign half_mag = half_cnt[`SSU_HCNT_W-1] ? (~half_cnt + 5'h01) : half_cnt;

    // Each half is shifted on its own, so nothing crosses the boundary
    genvar h;
    generate
        for (h = 0; h < 2; h++) begin : g_half
            logic [`SSU_HALF_W-1:0] part;
            assign part = port.value[h*`SSU_HALF_W +: `SSU_HALF_W];
            assign half_out[h*`SSU_HALF_W +: `SSU_HALF_W] = half_cnt[`SSU_HCNT_W-1]
                ? (part >> half_mag)
                : (part << half_mag);
        end
    endgenerate

    assign port.shifted = port.half_mode ? half_out : word_out;
endmodule : logical_shifter

// file: design/saturate_select_shift_unit.sv
// Function
// - Signed byte clamp to -128..127
// - Unsigned byte clamp to 255
// - Signed half clamp to -32768..32767
// - Unsigned half clamp to 65535
// - Short saturate form writes source register
// - Select first source when condition nonzero
// - Select-not first source when condition zero
// - Word shift count: signed six bits
// - Negative count shifts right, zero fill
// - Word count -32 gives zero
// - Short shift: four-bit count, writes source
// - Half-pair shift keeps halves separate
// - Half count five bits; -16 gives zero
// - Shift-in bit from equality
// - Shift-in greater-or-equal, signed or unsigned
// - Shift-in less-than, signed or unsigned
`timescale 1ns/10ps
`include "ssu_defines.svh"

module saturate_select_shift_unit (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    input wire ssu_pkg::op_t i_op,
    input wire logic i_short_form,
    input wire logic i_use_imm,
    input wire logic [`SSU_WORD_W-1:0] i_first_source,
    input wire logic [`SSU_WORD_W-1:0] i_second_source,
    input wire logic [`SSU_WORD_W-1:0] i_destination,
    input wire logic [`SSU_WORD_W-1:0] i_condition_operand,
    input wire logic [`SSU_IMM9_W-1:0] i_nine_bit_immediate,
    input wire logic [`SSU_IMM4_W-1:0] i_four_bit_immediate,
    input wire logic [`SSU_IDX_W-1:0] i_src_index,
    input wire logic [`SSU_IDX_W-1:0] i_dst_index,
    output logic o_valid,
    output logic [`SSU_WORD_W-1:0] o_result,
    output logic [`SSU_IDX_W-1:0] o_write_index
);
    import ssu_pkg::*;

    logic [`SSU_WORD_W-1:0] imm_sext;
    logic [`SSU_WORD_W-1:0] imm_zext;
    logic [`SSU_WORD_W-1:0] operand_b;
    logic [`SSU_WORD_W-1:0] sat_out;
    logic [`SSU_WORD_W-1:0] result_next;
    logic [`SSU_IDX_W-1:0] index_next;
    logic unsigned_cmp;
    logic cmp_bit;
    logic short_ok;
    logic [`SSU_WORD_W-1:0] o_result_reg;
    logic [`SSU_IDX_W-1:0] o_write_index_reg;
    logic o_valid_reg;

    shift_req_if sh_if ();

    logical_shifter u_shifter (
        .port(sh_if.shifter)
    );

    assign imm_sext = {{(`SSU_WORD_W-`SSU_IMM9_W){i_nine_bit_immediate[`SSU_IMM9_W-1]}},
                       i_nine_bit_immediate};
    assign imm_zext = {{(`SSU_WORD_W-`SSU_IMM9_W){1'b0}}, i_nine_bit_immediate};

    // Only the unsigned compare-and-shift forms zero-extend the immediate
    assign unsigned_cmp = (i_op == shift_in_ge_unsigned) || (i_op == shift_in_lt_unsigned);
    assign operand_b = i_use_imm ? (unsigned_cmp ? imm_zext : imm_sext)
                                 : i_second_source;

    // Saturation
    always_comb begin
        case (i_op)
            clamp_signed_byte: begin
                if ($signed(i_first_source) < $signed(`SSU_SB_MIN)) begin
                    sat_out = `SSU_SB_MIN;
                end else if ($signed(i_first_source) > $signed(`SSU_SB_MAX)) begin
                    sat_out = `SSU_SB_MAX;
                end else begin
                    sat_out = i_first_source;
                end
            end
            clamp_unsigned_byte: begin
                sat_out = (i_first_source > `SSU_UB_MAX) ? `SSU_UB_MAX : i_first_source;
            end
            clamp_signed_half: begin
                if ($signed(i_first_source) < $signed(`SSU_SH_MIN)) begin
                    sat_out = `SSU_SH_MIN;
                end else if ($signed(i_first_source) > $signed(`SSU_SH_MAX)) begin
                    sat_out = `SSU_SH_MAX;
                end else begin
                    sat_out = i_first_source;
                end
            end
            clamp_unsigned_half: begin
                sat_out = (i_first_source > `SSU_UH_MAX) ? `SSU_UH_MAX : i_first_source;
            end
            default: begin
                sat_out = i_first_source;
            end
        endcase
    end

    // Shift count: short form sign-extends the four-bit immediate
    assign sh_if.value = i_first_source;
    assign sh_if.half_mode = (i_op == logical_half_pair_shift);
    assign sh_if.count = (i_short_form && i_op == logical_word_shift)
        ? {{(`SSU_WCNT_W-`SSU_IMM4_W){i_four_bit_immediate[`SSU_IMM4_W-1]}},
           i_four_bit_immediate}
        : operand_b[`SSU_WCNT_W-1:0];

    // Comparison bit for the shift-in family
    always_comb begin
        case (i_op)
            shift_in_equal: cmp_bit = (i_first_source == operand_b);
            shift_in_ge_signed: cmp_bit = ($signed(i_first_source) >= $signed(operand_b));
            shift_in_ge_unsigned: cmp_bit = (i_first_source >= operand_b);
            shift_in_lt_signed: cmp_bit = ($signed(i_first_source) < $signed(operand_b));
            shift_in_lt_unsigned: cmp_bit = (i_first_source < operand_b);
            default: cmp_bit = 1'b0;
        endcase
    end

    // Short forms exist only for saturation and the word shift
    always_comb begin
        case (i_op)
            clamp_signed_byte, clamp_unsigned_byte,
            clamp_signed_half, clamp_unsigned_half,
            logical_word_shift: short_ok = i_short_form;
            default: short_ok = 1'b0;
        endcase
    end

    always_comb begin
        case (i_op)
            clamp_signed_byte, clamp_unsigned_byte,
            clamp_signed_half, clamp_unsigned_half: result_next = sat_out;
            select_on_set: begin
                result_next = (i_condition_operand != `SSU_ZERO) ? i_first_source
                                                                 : operand_b;
            end
            select_on_clear: begin
                result_next = (i_condition_operand == `SSU_ZERO) ? i_first_source
                                                                 : operand_b;
            end
            logical_word_shift, logical_half_pair_shift: result_next = sh_if.shifted;
            shift_in_equal, shift_in_ge_signed, shift_in_ge_unsigned,
            shift_in_lt_signed, shift_in_lt_unsigned: begin
                result_next = {i_destination[`SSU_MSB-1:0], cmp_bit};
            end
            default: result_next = i_first_source;
        endcase
    end

    assign index_next = short_ok ? i_src_index : i_dst_index;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_valid_reg <= 1'b0;
        end else begin
            o_valid_reg <= i_valid && (i_op != op_idle);
        end
    end

    // Result and index hold while i_valid is low; an op_idle issue still loads them
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_result_reg <= `SSU_RST_RESULT;
        end else if (i_valid) begin
            o_result_reg <= result_next;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_write_index_reg <= `SSU_RST_INDEX;
        end else if (i_valid) begin
            o_write_index_reg <= index_next;
        end
    end

    assign o_valid = o_valid_reg;
    assign o_result = o_result_reg;
    assign o_write_index = o_write_index_reg;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_issue(op_t op);
        i_valid && i_op == op;
    endsequence

    sequence s_shift_in;
        i_valid && (i_op == shift_in_equal || i_op == shift_in_ge_signed ||
                    i_op == shift_in_ge_unsigned || i_op == shift_in_lt_signed ||
                    i_op == shift_in_lt_unsigned);
    endsequence

    a_byte_signed_clamp:
    assert property (s_issue(clamp_signed_byte) |=>
        o_valid && $signed(o_result) >= -128 && $signed(o_result) <= 127 &&
        (($signed($past(i_first_source)) < -128) ? $signed(o_result) == -128 :
         ($signed($past(i_first_source)) > 127) ? $signed(o_result) == 127 :
         o_result == $past(i_first_source)))
        else $error("signed byte clamp wrong");

    a_byte_unsigned_clamp:
    assert property (s_issue(clamp_unsigned_byte) |=>
        o_result == (($past(i_first_source) > 32'd255) ? 32'd255 : $past(i_first_source)))
        else $error("unsigned byte clamp wrong");

    a_half_signed_clamp:
    assert property (s_issue(clamp_signed_half) |=>
        (($signed($past(i_first_source)) < -32768) ? $signed(o_result) == -32768 :
         ($signed($past(i_first_source)) > 32767) ? $signed(o_result) == 32767 :
         o_result == $past(i_first_source)))
        else $error("signed half clamp wrong");

    a_half_unsigned_clamp:
    assert property (s_issue(clamp_unsigned_half) |=>
        o_result == (($past(i_first_source) > 32'd65535) ? 32'd65535 : $past(i_first_source)))
        else $error("unsigned half clamp wrong");

    a_short_writeback:
    assert property (i_valid && i_short_form && i_op inside {clamp_signed_byte,
        clamp_unsigned_byte, clamp_signed_half, clamp_unsigned_half} |=>
        o_write_index == $past(i_src_index))
        else $error("short saturate form wrote wrong register");

    a_select_pick:
    assert property (s_issue(select_on_set) |=>
        o_result == (($past(i_condition_operand) != 0) ? $past(i_first_source)
                                                       : $past(operand_b)))
        else $error("select picked wrong operand");

    a_select_not_pick:
    assert property (s_issue(select_on_clear) ##0 (i_condition_operand == 0) |=>
        o_result == $past(i_first_source))
        else $error("select-not picked wrong operand");

    a_word_shift_zero:
    assert property (s_issue(logical_word_shift) ##0 (!i_short_form &&
        operand_b[5:0] == 6'h20) |=> o_result == 0)
        else $error("shift by -32 not zero");

    a_word_shift_left:
    assert property (s_issue(logical_word_shift) ##0 (!i_short_form && !operand_b[5]) |=>
        o_result == ($past(i_first_source) << $past(operand_b[4:0])))
        else $error("left word shift wrong");

    a_short_shift_index:
    assert property (s_issue(logical_word_shift) ##0 i_short_form |=>
        o_write_index == $past(i_src_index) &&
        (($past(i_four_bit_immediate[3])) ?
         o_result == ($past(i_first_source) >> (5'd16 - $past(i_four_bit_immediate))) :
         o_result == ($past(i_first_source) << $past(i_four_bit_immediate))))
        else $error("short shift wrong");

    a_half_no_carry:
    assert property (s_issue(logical_half_pair_shift) ##0 (operand_b[4:0] == 5'h10) |=>
        o_result == 0)
        else $error("half shift by -16 not zero");

    a_shift_in_bit:
    assert property (s_shift_in |=>
        o_result[31:1] == $past(i_destination[30:0]) && o_result[0] == $past(cmp_bit))
        else $error("shift-in lost destination bits");

    a_shift_in_eq:
    assert property (s_issue(shift_in_equal) ##0 (i_first_source == operand_b) |=>
        o_result[0])
        else $error("equal compare bit not set");

    a_shift_in_lt:
    assert property (s_issue(shift_in_lt_unsigned) |=>
        o_result[0] == ($past(i_first_source) < $past(operand_b)))
        else $error("unsigned less-than bit wrong");

    a_ge_imm_zext:
    assert property (s_issue(shift_in_ge_unsigned) ##0 i_use_imm |=>
        o_result[0] == ($past(i_first_source) >= {23'h0, $past(i_nine_bit_immediate)}))
        else $error("unsigned ge immediate not zero-extended");

endmodule : saturate_select_shift_unit

// file: design/shift_req_if.sv
`timescale 1ns/10ps
`include "ssu_defines.svh"

interface shift_req_if;
    logic [`SSU_WORD_W-1:0] value;
    logic [`SSU_WCNT_W-1:0] count;
    logic half_mode;
    logic [`SSU_WORD_W-1:0] shifted;

    modport requester (output value, output count, output half_mode, input shifted);
    modport shifter (input value, input count, input half_mode, output shifted);
endinterface : shift_req_if

// file: design/ssu_defines.svh
`ifndef SSU_DEFINES_SVH
`define SSU_DEFINES_SVH

`define SSU_WORD_W 32
`define SSU_HALF_W 16
`define SSU_IDX_W 4
`define SSU_IMM9_W 9
`define SSU_IMM4_W 4
`define SSU_WCNT_W 6
`define SSU_HCNT_W 5
`define SSU_MSB 31
`define SSU_HALF_MSB 15

`define SSU_SB_MIN 32'hFFFFFF80
`define SSU_SB_MAX 32'h0000007F
`define SSU_UB_MAX 32'h000000FF
`define SSU_SH_MIN 32'hFFFF8000
`define SSU_SH_MAX 32'h00007FFF
`define SSU_UH_MAX 32'h0000FFFF
`define SSU_ZERO 32'h00000000

`define SSU_RST_RESULT 32'h00000000
`define SSU_RST_INDEX 4'h0

`endif

// file: design/ssu_pkg.sv
package ssu_pkg;
    typedef enum logic [3:0] {
        clamp_signed_byte,
        clamp_unsigned_byte,
        clamp_signed_half,
        clamp_unsigned_half,
        select_on_set,
        select_on_clear,
        logical_word_shift,
        logical_half_pair_shift,
        shift_in_equal,
        shift_in_ge_signed,
        shift_in_ge_unsigned,
        shift_in_lt_signed,
        shift_in_lt_unsigned,
        op_idle
    } op_t;
endpackage : ssu_pkg

// file: testbench/saturate_select_shift_unit_tb_top.sv
`timescale 1ns/10ps

`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin errors++; \
    $display("ERROR %0t: got %h expected %h", $time, got, exp); end end

module saturate_select_shift_unit_tb_top;
    import ssu_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_valid = 1'b0;
    logic i_short_form = 1'b0;
    logic i_use_imm = 1'b0;
    op_t i_op = op_idle;
    logic [31:0] i_first_source = 32'h0;
    logic [31:0] i_second_source = 32'h0;
    logic [31:0] i_destination = 32'h0;
    logic [31:0] i_condition_operand = 32'h0;
    logic [8:0] i_nine_bit_immediate = 9'h0;
    logic [3:0] i_four_bit_immediate = 4'h0;
    logic [3:0] i_src_index = 4'h5;
    logic [3:0] i_dst_index = 4'h9;
    logic o_valid;
    logic [31:0] o_result;
    logic [3:0] o_write_index;
    logic [31:0] rd_data;
    int errors = 0;
    int cmp_count = 0;

    saturate_select_shift_unit dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_valid(i_valid),
        .i_op(i_op), .i_short_form(i_short_form), .i_use_imm(i_use_imm),
        .i_first_source(i_first_source), .i_second_source(i_second_source),
        .i_destination(i_destination), .i_condition_operand(i_condition_operand),
        .i_nine_bit_immediate(i_nine_bit_immediate),
        .i_four_bit_immediate(i_four_bit_immediate), .i_src_index(i_src_index),
        .i_dst_index(i_dst_index), .o_valid(o_valid), .o_result(o_result),
        .o_write_index(o_write_index));

    ssu_regfile rf_u (.i_clk(i_clk), .i_rst(i_rst), .i_we(o_valid), .i_idx(o_write_index),
        .i_data(o_result), .i_rd_idx(i_src_index), .o_rd_data(rd_data));

    initial begin
        forever #25 i_clk = ~i_clk;
    end

    task wrap_up;
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    // Issues one op; inputs stay put until the answer is checked one cycle later
    // Short form only retargets saturates and the word shift; others keep the destination
    task run(input op_t op, input logic [31:0] a, input logic [31:0] b, input logic [31:0] exp);
        logic [3:0] exp_idx;
        exp_idx = (i_short_form && (op inside {clamp_signed_byte, clamp_unsigned_byte,
            clamp_signed_half, clamp_unsigned_half, logical_word_shift})) ? i_src_index
                                                                          : i_dst_index;
        i_op = op;
        i_first_source = a;
        i_second_source = b;
        i_valid = 1'b1;
        @(posedge i_clk);
        #1;
        `CHK(o_valid, 1'b1)
        `CHK(o_result, exp)
        `CHK(o_write_index, exp_idx)
    endtask : run

    task t_saturate;
        run(clamp_signed_byte, 32'h0000012C, 32'h0, 32'h0000007F);
        run(clamp_signed_byte, 32'hFFFFFF7F, 32'h0, 32'hFFFFFF80);
        run(clamp_signed_byte, 32'hFFFFFF80, 32'h0, 32'hFFFFFF80);
        run(clamp_unsigned_byte, 32'hFFFFFFFF, 32'h0, 32'h000000FF);
        run(clamp_unsigned_byte, 32'h000000FF, 32'h0, 32'h000000FF);
        run(clamp_signed_half, 32'h00008000, 32'h0, 32'h00007FFF);
        run(clamp_signed_half, 32'hFFFF7FFF, 32'h0, 32'hFFFF8000);
        run(clamp_unsigned_half, 32'h00010000, 32'h0, 32'h0000FFFF);
        run(clamp_unsigned_half, 32'h0000FFFF, 32'h0, 32'h0000FFFF);
    endtask : t_saturate

    task t_short;
        i_short_form = 1'b1;
        run(clamp_signed_byte, 32'h00000200, 32'h0, 32'h0000007F);
        run(clamp_unsigned_half, 32'h00001234, 32'h0, 32'h00001234);
        i_four_bit_immediate = 4'h8;
        // Second source holds a different count to catch the wrong operand
        run(logical_word_shift, 32'h00000F00, 32'h0000001F, 32'h0000000F);
        // Short flag has no meaning here: count comes from the operand, index stays long
        run(logical_half_pair_shift, 32'h00010001, 32'h00000001, 32'h00020002);
        run(select_on_set, 32'h11112222, 32'h33334444, 32'h33334444);
        i_four_bit_immediate = 4'h7;
        run(logical_word_shift, 32'h00000001, 32'h0000001F, 32'h00000080);
        i_valid = 1'b0;
        @(posedge i_clk);
        #1;
        `CHK(rd_data, 32'h00000080)
        i_short_form = 1'b0;
    endtask : t_short

    task t_select;
        i_condition_operand = 32'h00000001;
        run(select_on_set, 32'h11112222, 32'h33334444, 32'h11112222);
        i_condition_operand = 32'h0;
        run(select_on_set, 32'h11112222, 32'h33334444, 32'h33334444);
        run(select_on_clear, 32'h11112222, 32'h33334444, 32'h11112222);
        i_use_imm = 1'b1;
        i_nine_bit_immediate = 9'h1F0;
        run(select_on_set, 32'h11112222, 32'h33334444, 32'hFFFFFFF0);
        i_condition_operand = 32'h80000000;
        run(select_on_clear, 32'h11112222, 32'h33334444, 32'hFFFFFFF0);
        i_use_imm = 1'b0;
        run(select_on_clear, 32'h11112222, 32'h33334444, 32'h33334444);
    endtask : t_select

    task t_word_shift;
        run(logical_word_shift, 32'h80000001, 32'hFFFFFF1F, 32'h80000000);
        run(logical_word_shift, 32'h80000001, 32'h0000003F, 32'h40000000);
        run(logical_word_shift, 32'hFFFFFFFF, 32'h00000021, 32'h00000001);
        run(logical_word_shift, 32'hFFFFFFFF, 32'h00000020, 32'h0);
        i_use_imm = 1'b1;
        i_nine_bit_immediate = 9'h1FC;
        run(logical_word_shift, 32'h000000F0, 32'h0, 32'h0000000F);
        i_use_imm = 1'b0;
    endtask : t_word_shift

    task t_half_shift;
        run(logical_half_pair_shift, 32'h00018000, 32'h0000001F, 32'h00004000);
        run(logical_half_pair_shift, 32'h00008001, 32'h00000001, 32'h00000002);
        run(logical_half_pair_shift, 32'hFFFFFFFF, 32'h00000010, 32'h0);
        run(logical_half_pair_shift, 32'h00010001, 32'h0000002F, 32'h80008000);
        i_use_imm = 1'b1;
        i_nine_bit_immediate = 9'h1F1;
        run(logical_half_pair_shift, 32'h80008000, 32'h0, 32'h00010001);
        i_use_imm = 1'b0;
    endtask : t_half_shift

    task t_shift_in;
        i_destination = 32'h80000001;
        run(shift_in_equal, 32'h00000005, 32'h00000005, 32'h00000003);
        run(shift_in_equal, 32'h00000005, 32'h00000006, 32'h00000002);
        run(shift_in_ge_signed, 32'hFFFFFFFF, 32'h00000001, 32'h00000002);
        run(shift_in_ge_unsigned, 32'hFFFFFFFF, 32'h00000001, 32'h00000003);
        run(shift_in_lt_signed, 32'hFFFFFFFF, 32'h00000001, 32'h00000003);
        run(shift_in_lt_unsigned, 32'hFFFFFFFF, 32'h00000001, 32'h00000002);
        i_use_imm = 1'b1;
        i_nine_bit_immediate = 9'h100;
        run(shift_in_equal, 32'hFFFFFF00, 32'h0, 32'h00000003);
        run(shift_in_ge_signed, 32'h00000050, 32'h0, 32'h00000003);
        run(shift_in_ge_unsigned, 32'h00000050, 32'h0, 32'h00000002);
        run(shift_in_lt_signed, 32'h00000050, 32'h0, 32'h00000002);
        run(shift_in_lt_unsigned, 32'h00000050, 32'h0, 32'h00000003);
        i_use_imm = 1'b0;
    endtask : t_shift_in

    task t_idle_reset;
        i_op = op_idle;
        @(posedge i_clk);
        #1;
        `CHK(o_valid, 1'b0)
        `CHK(o_result, 32'h00000050)
        i_valid = 1'b0;
        i_rst = 1'b1;
        @(posedge i_clk);
        #1;
        `CHK(o_valid, 1'b0)
        `CHK(o_result, 32'h0)
        `CHK(o_write_index, 4'h0)
        i_rst = 1'b0;
    endtask : t_idle_reset

    // A hang must still end in the closing report
    initial begin
        #1000000;
        errors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        t_saturate();
        t_short();
        t_select();
        t_word_shift();
        t_half_shift();
        t_shift_in();
        t_idle_reset();
        t_saturate();
        wrap_up();
    end
endmodule : saturate_select_shift_unit_tb_top

// file: testbench/ssu_regfile.sv
`timescale 1ns/10ps

// Core data registers as seen from the write-back side of the unit
module ssu_regfile (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [3:0] i_idx,
    input wire logic [31:0] i_data,
    input wire logic [3:0] i_rd_idx,
    output logic [31:0] o_rd_data
);
    logic [31:0] regs_reg [16];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 16; k++) begin
                regs_reg[k] <= 32'h0;
            end
        end else if (i_we) begin
            regs_reg[i_idx] <= i_data;
        end
    end

    assign o_rd_data = regs_reg[i_rd_idx];
endmodule : ssu_regfile
